// File: src/cwd_mode_latch.sv
`default_nettype none
// catches the i/o addressing mode strap once, on the first edge after reset release
module cwd_mode_latch
    import cwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic io32_strap,
    output logic io32_mode
);
    logic taken_q;
    logic mode_q;

    // strap is sampled after release, never through the reset path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            taken_q <= 1'b0;
            mode_q <= 1'b0;
        end else if (!taken_q) begin
            taken_q <= 1'b1;
            mode_q <= io32_strap;
        end
    end

    assign io32_mode = mode_q;
endmodule
`default_nettype wire

// File: src/cwd_pkg.sv
`default_nettype none
package cwd_pkg;
    // configuration offsets, byte addresses of each window register
    localparam logic [7:0] CWD_OFF_MEM0_TOP = 8'h20;
    localparam logic [7:0] CWD_OFF_MEM1_BOTTOM = 8'h24;
    localparam logic [7:0] CWD_OFF_MEM1_TOP = 8'h28;
    localparam logic [7:0] CWD_OFF_IO0_BOTTOM_LOW = 8'h2c;
    localparam logic [7:0] CWD_OFF_IO0_BOTTOM_HIGH = 8'h2e;

    // field positions
    localparam int CWD_MEM_LSB = 12;
    localparam int CWD_IO_LSB = 2;
    localparam int CWD_CMD_IO_EN_BIT = 0;
    localparam int CWD_CMD_MEM_EN_BIT = 1;
    localparam int CWD_BCTL_MEM1_PF_BIT = 8;

    // reset values
    localparam logic [19:0] CWD_MEM_RST = 20'h00000;
    localparam logic [13:0] CWD_IO_LOW_RST = 14'h0000;
    localparam logic [15:0] CWD_IO_HIGH_RST = 16'h0000;

    // read-only addressing mode code in bits 1..0 of the i/o base
    localparam logic [1:0] CWD_IOMODE_16 = 2'h0;
    localparam logic [1:0] CWD_IOMODE_32 = 2'h1;

    // decode latency from request to answer, in clocks
    localparam int CWD_DECODE_LAT = 1;

    typedef enum logic [1:0] {
        CWD_WIN_NONE,
        CWD_WIN_MEM0,
        CWD_WIN_MEM1,
        CWD_WIN_IO0
    } cwd_win_e;

    // one transaction presented on the primary side for decode
    typedef struct packed {
        logic valid;
        logic is_io;
        logic [31:0] addr;
    } cwd_txn_s;

    // decode answer: forward to the card side or not
    typedef struct packed {
        logic valid;
        logic fwd;
        cwd_win_e win;
        logic prefetch;
    } cwd_result_s;
endpackage
`default_nettype wire

// File: src/cwd_range_cmp.sv
`default_nettype none
// unsigned inclusive range check, limit taken with its low bits all ones
module cwd_range_cmp #(
    parameter int W = 20
) (
    input wire logic [W-1:0] addr,
    input wire logic [W-1:0] bottom,
    input wire logic [W-1:0] top,
    output logic hit
);
    // comparing only the upper bits makes the dropped low bits of the top act as ones
    assign hit = (addr >= bottom) && (addr <= top); // [RULE2] [RULE19] [RULE4]
endmodule
`default_nettype wire

// File: src/cwd_window_decode.sv
`default_nettype none
// Function
// RULE1: memory registers keep bits 31..12, low zero
// RULE2: limit low twelve bits decode as ones
// RULE3: memory windows need memory-space enable
// RULE4: limit below base never hits
// RULE5: window 1 gated by command bit 1
// RULE6: bridge control bit 8 sets prefetchable
// RULE7: software clears prefetch only for side effects
// RULE8: memory hit forwards transaction to card
// RULE9: legacy 16-bit card disables window decode
// RULE10: i/o base low holds bits 15..2
// RULE11: i/o base bits 1..0 report mode
// RULE12: 16-bit mode zeros upper base bits
// RULE13: upper base half writable in 32-bit mode
// RULE14: i/o window needs i/o-space enable
// RULE15: i/o hit forwards transaction to card
// RULE16: writes to read-only low bits ignored
// RULE17: both i/o base halves reset zero
// RULE18: i/o top comes from limit register
// RULE19: hit is unsigned base <= addr <= limit
module cwd_window_decode
    import cwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // configuration access port
    input wire logic cfg_sel,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic cfg_claim,
    output logic [31:0] cfg_rdata,
    // state held by neighbouring configuration registers, plus the mode strap and card presence
    input wire logic [15:0] pci_command,
    input wire logic [15:0] bridge_control,
    input wire logic [31:0] mem_window0_bottom,
    input wire logic [31:0] io_window0_top,
    input wire logic io32_strap,
    input wire logic legacy_16bit_card,
    // transaction decode
    input wire cwd_txn_s txn,
    output cwd_result_s result
);
    logic [19:0] mem0_top_q;
    logic [19:0] mem1_bottom_q;
    logic [19:0] mem1_top_q;
    logic [13:0] io0_low_q;
    logic [15:0] io0_high_q;
    logic io32_mode;
    logic [1:0] io_mode_code;
    logic wr_mem0_top;
    logic wr_mem1_bottom;
    logic wr_mem1_top;
    logic wr_io0;
    logic [31:0] mem0_top_next;
    logic [31:0] mem1_bottom_next;
    logic [31:0] mem1_top_next;
    logic [31:0] io0_next;
    logic [31:0] rd_d;
    logic claim_d;
    logic [31:0] io_bottom_eff;
    logic [31:0] io_top_eff;
    logic mem0_in;
    logic mem1_in;
    logic io0_in;
    logic mem_en;
    logic io_en;
    logic card_ok;
    cwd_result_s result_d;
    cwd_result_s result_q;
    logic ack_q;
    logic claim_q;
    logic [31:0] rdata_q;

    // byte-lane merge used by every register write
    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wdata[8*i +: 8];
            end
        end
        return r;
    endfunction

    // dword address match; the two i/o halves share the 2c dword
    function automatic logic at_dword(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    cwd_mode_latch u_mode (
        .clk(clk),
        .rst_n(rst_n),
        .io32_strap(io32_strap),
        .io32_mode(io32_mode)
    );

    // mode code shown in the low bits of the i/o base
    assign io_mode_code = io32_mode ? CWD_IOMODE_32 : CWD_IOMODE_16; // [RULE11]

    // write strobes
    assign wr_mem0_top = cfg_sel && cfg_wr && at_dword(cfg_addr, CWD_OFF_MEM0_TOP);
    assign wr_mem1_bottom = cfg_sel && cfg_wr && at_dword(cfg_addr, CWD_OFF_MEM1_BOTTOM);
    assign wr_mem1_top = cfg_sel && cfg_wr && at_dword(cfg_addr, CWD_OFF_MEM1_TOP);
    assign wr_io0 = cfg_sel && cfg_wr && at_dword(cfg_addr, CWD_OFF_IO0_BOTTOM_LOW);

    // merged words; only writable fields are kept, so low bits stay fixed
    assign mem0_top_next = merge_be({mem0_top_q, 12'h000}, cfg_wdata, cfg_be);
    assign mem1_bottom_next = merge_be({mem1_bottom_q, 12'h000}, cfg_wdata, cfg_be);
    assign mem1_top_next = merge_be({mem1_top_q, 12'h000}, cfg_wdata, cfg_be);
    assign io0_next = merge_be({io0_high_q, io0_low_q, io_mode_code}, cfg_wdata, cfg_be);

    // memory window registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem0_top_q <= CWD_MEM_RST;
            mem1_bottom_q <= CWD_MEM_RST;
            mem1_top_q <= CWD_MEM_RST;
        end else begin
            if (wr_mem0_top) begin
                mem0_top_q <= mem0_top_next[31:CWD_MEM_LSB]; // [RULE1] [RULE16]
            end
            if (wr_mem1_bottom) begin
                mem1_bottom_q <= mem1_bottom_next[31:CWD_MEM_LSB]; // [RULE1] [RULE16]
            end
            if (wr_mem1_top) begin
                mem1_top_q <= mem1_top_next[31:CWD_MEM_LSB]; // [RULE1] [RULE16]
            end
        end
    end

    // i/o base halves; upper half is locked out in 16-bit mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            io0_low_q <= CWD_IO_LOW_RST; // [RULE17]
            io0_high_q <= CWD_IO_HIGH_RST; // [RULE17]
        end else if (wr_io0) begin
            io0_low_q <= io0_next[15:CWD_IO_LSB]; // [RULE10] [RULE16]
            if (io32_mode) begin
                io0_high_q <= io0_next[31:16]; // [RULE13]
            end
        end
    end

    // read mux; unclaimed offsets read zero and are left to other registers
    always_comb begin
        rd_d = 32'h00000000;
        claim_d = 1'b1;
        if (at_dword(cfg_addr, CWD_OFF_MEM0_TOP)) begin
            rd_d = {mem0_top_q, 12'h000}; // [RULE1]
        end else if (at_dword(cfg_addr, CWD_OFF_MEM1_BOTTOM)) begin
            rd_d = {mem1_bottom_q, 12'h000}; // [RULE1]
        end else if (at_dword(cfg_addr, CWD_OFF_MEM1_TOP)) begin
            rd_d = {mem1_top_q, 12'h000}; // [RULE1]
        end else if (at_dword(cfg_addr, CWD_OFF_IO0_BOTTOM_LOW)) begin
            rd_d = {io0_high_q, io0_low_q, io_mode_code}; // [RULE11]
        end else begin
            claim_d = 1'b0;
        end
    end

    // configuration answer one clock after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            claim_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= cfg_sel;
            claim_q <= cfg_sel && claim_d;
            if (cfg_sel && !cfg_wr) begin
                rdata_q <= rd_d;
            end
        end
    end

    assign cfg_ack = ack_q;
    assign cfg_claim = claim_q;
    assign cfg_rdata = rdata_q;

    // effective i/o bounds; in 16-bit mode the upper halves count as zero
    assign io_bottom_eff = io32_mode ? {io0_high_q, io0_low_q, 2'h0}
                                     : {16'h0000, io0_low_q, 2'h0}; // [RULE12]
    // the top bound is owned by the limit register at 30h
    assign io_top_eff = io32_mode ? io_window0_top
                                  : {16'h0000, io_window0_top[15:0]}; // [RULE18]

    cwd_range_cmp #(.W(20)) u_mem0 (
        .addr(txn.addr[31:CWD_MEM_LSB]),
        .bottom(mem_window0_bottom[31:CWD_MEM_LSB]),
        .top(mem0_top_q),
        .hit(mem0_in)
    );

    cwd_range_cmp #(.W(20)) u_mem1 (
        .addr(txn.addr[31:CWD_MEM_LSB]),
        .bottom(mem1_bottom_q),
        .top(mem1_top_q),
        .hit(mem1_in)
    );

    // dword granularity for i/o, so the top's two low bits act as ones
    cwd_range_cmp #(.W(30)) u_io0 (
        .addr(txn.addr[31:CWD_IO_LSB]),
        .bottom(io_bottom_eff[31:CWD_IO_LSB]),
        .top(io_top_eff[31:CWD_IO_LSB]),
        .hit(io0_in)
    );

    // global gates
    assign mem_en = pci_command[CWD_CMD_MEM_EN_BIT]; // [RULE3] [RULE5]
    assign io_en = pci_command[CWD_CMD_IO_EN_BIT]; // [RULE14]
    assign card_ok = !legacy_16bit_card; // [RULE9]

    // decode; window 0 wins if software lets the two memory windows overlap
    always_comb begin
        result_d = '0;
        result_d.valid = txn.valid;
        result_d.win = CWD_WIN_NONE;
        if (txn.valid && card_ok) begin
            if (txn.is_io) begin
                if (io_en && io0_in) begin
                    result_d.fwd = 1'b1; // [RULE15]
                    result_d.win = CWD_WIN_IO0;
                end
            end else if (mem_en && mem0_in) begin
                result_d.fwd = 1'b1; // [RULE8]
                result_d.win = CWD_WIN_MEM0;
            end else if (mem_en && mem1_in) begin
                result_d.fwd = 1'b1; // [RULE8]
                result_d.win = CWD_WIN_MEM1;
                // software keeps this set unless reads have side effects
                result_d.prefetch = bridge_control[CWD_BCTL_MEM1_PF_BIT]; // [RULE6] [RULE7]
            end
        end
    end

    // answer registered, one clock after the request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_q <= '0;
        end else begin
            result_q <= result_d;
        end
    end

    assign result = result_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_mem_low_zero: assert property ( // [RULE1]
        cfg_sel && !cfg_wr && (at_dword(cfg_addr, CWD_OFF_MEM0_TOP)
            || at_dword(cfg_addr, CWD_OFF_MEM1_TOP)) |=> cfg_rdata[11:0] == 12'h000)
        else $error("memory window low bits not zero");

    a_mem_wr_store: assert property ( // [RULE1]
        wr_mem1_bottom && cfg_be == 4'hf |=>
            mem1_bottom_q == $past(cfg_wdata[31:12]))
        else $error("memory base write lost");

    a_same_4k_hit: assert property ( // [RULE2]
        txn.valid && !txn.is_io && mem_en && card_ok && !mem0_in
            && mem1_bottom_q == mem1_top_q && txn.addr[31:12] == mem1_top_q
            |=> result.fwd && result.win == CWD_WIN_MEM1)
        else $error("equal base and limit did not give a 4k window");

    a_mem_en_gate: assert property ( // [RULE3] [RULE5]
        txn.valid && !txn.is_io && !pci_command[CWD_CMD_MEM_EN_BIT] |=> !result.fwd)
        else $error("memory forward while memory space disabled");

    a_inverted_off: assert property ( // [RULE4]
        txn.valid && !txn.is_io && mem1_top_q < mem1_bottom_q && !mem0_in
            |=> !result.fwd)
        else $error("inverted window produced a hit");

    a_prefetch_bit: assert property ( // [RULE6]
        result.fwd && result.win == CWD_WIN_MEM1 |->
            result.prefetch == $past(bridge_control[CWD_BCTL_MEM1_PF_BIT]))
        else $error("prefetch flag does not follow control bit");

    a_legacy_block: assert property ( // [RULE9]
        txn.valid && legacy_16bit_card |=> result.valid && !result.fwd)
        else $error("decode hit with legacy card in socket");

    a_io_mode_code: assert property ( // [RULE11]
        cfg_sel && !cfg_wr && at_dword(cfg_addr, CWD_OFF_IO0_BOTTOM_LOW)
            |=> cfg_rdata[1:0] == (io32_mode ? 2'h1 : 2'h0))
        else $error("i/o mode code wrong");

    a_io_high_lock: assert property ( // [RULE13] [RULE12]
        wr_io0 && !io32_mode |=> $stable(io0_high_q))
        else $error("upper i/o base written in 16-bit mode");

    a_io_en_gate: assert property ( // [RULE14] [RULE15]
        txn.valid && txn.is_io ##1 result.fwd |-> $past(io_en) && result.win == CWD_WIN_IO0)
        else $error("i/o forward without i/o space enable");
endmodule
`default_nettype wire

// File: test/cwd_host_model.sv
`default_nettype none
// neighbouring config state and card presence, set by the bench at will
module cwd_host_model
    import cwd_pkg::*;
(
    output var logic [15:0] pci_command,
    output var logic [15:0] bridge_control,
    output var logic [31:0] mem_window0_bottom,
    output var logic [31:0] io_window0_top,
    output var logic io32_strap,
    output var logic legacy_16bit_card
);
    timeunit 1ns;
    timeprecision 1ps;

    // power-up state of the software side
    initial begin
        pci_command = 16'h0000;
        bridge_control = 16'h0100; // prefetch until side effects are known
        mem_window0_bottom = 32'h0000_0000;
        io_window0_top = 32'h0000_0000; // i/o top from the limit register
        io32_strap = 1'b0;
        legacy_16bit_card = 1'b0;
    end
endmodule
`default_nettype wire

// File: test/tb_cardbus_window_decode.sv
`default_nettype none
module tb_cardbus_window_decode
    import cwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_sel = 1'b0;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [31:0] cfg_rdata;
    logic cfg_ack;
    logic cfg_claim;
    logic [15:0] pci_command;
    logic [15:0] bridge_control;
    logic [31:0] mem_window0_bottom;
    logic [31:0] io_window0_top;
    logic io32_strap;
    logic legacy_16bit_card;
    cwd_txn_s txn_i = '0;
    cwd_result_s result;
    int mismatches = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'd22957;
    logic [31:0] m0t, m1b, m1t;
    logic [15:0] iol, ioh;
    logic md32;
    logic [33:0] cq[$];
    cwd_result_s rq[$];
    logic [33:0] ce;
    logic [7:0] offs [5] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
    logic [32:0] sw [11] = '{33'h0_10000fff, 33'h0_10001000, 33'h0_0ffff000, 33'h0_20000000,
        33'h0_20003fff, 33'h0_20004000, 33'h1_00001000, 33'h1_00000ffc, 33'h1_000010fc,
        33'h1_00001100, 33'h1_00011000};

    always #5 clk = ~clk;

    cwd_host_model host (.pci_command, .bridge_control, .mem_window0_bottom, .io_window0_top,
        .io32_strap, .legacy_16bit_card);

    cwd_window_decode uut (.clk, .rst_n, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
        .cfg_ack, .cfg_claim, .cfg_rdata, .pci_command, .bridge_control, .mem_window0_bottom,
        .io_window0_top, .io32_strap, .legacy_16bit_card, .txn(txn_i), .result);

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected decode worked out from the window rules
    function automatic cwd_result_s dec(input logic io, input logic [31:0] a);
        cwd_result_s r;
        logic [29:0] b, t;
        r = '0;
        r.valid = 1'b1;
        b = {md32 ? ioh : 16'h0, iol[15:2]};
        t = {md32 ? io_window0_top[31:16] : 16'h0, io_window0_top[15:2]};
        if (legacy_16bit_card) return r;
        if (!io && pci_command[1]) begin
            if (a[31:12] >= mem_window0_bottom[31:12] && a[31:12] <= m0t[31:12]) begin
                r.win = CWD_WIN_MEM0;
            end else if (a[31:12] >= m1b[31:12] && a[31:12] <= m1t[31:12]) begin
                r.win = CWD_WIN_MEM1;
                r.prefetch = bridge_control[8];
            end
        end
        if (io && pci_command[0] && a[31:2] >= b && a[31:2] <= t) r.win = CWD_WIN_IO0;
        r.fwd = (r.win != CWD_WIN_NONE);
        return r;
    endfunction

    // one config access; shadow registers keep only the writable fields
    task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        if (w && a inside {8'h20, 8'h24, 8'h28}) begin
            if (a == 8'h20) m0t = d & 32'hffff_f000;
            if (a == 8'h24) m1b = d & 32'hffff_f000;
            if (a == 8'h28) m1t = d & 32'hffff_f000;
        end
        if (w && a == 8'h2c) begin
            iol = d[15:0] & 16'hfffc;
            if (md32) ioh = d[31:16];
        end
        case (a)
            8'h20: v = m0t;
            8'h24: v = m1b;
            8'h28: v = m1t;
            8'h2c: v = {ioh, iol[15:2], md32 ? CWD_IOMODE_32 : CWD_IOMODE_16};
            default: v = 32'h0;
        endcase
        cq.push_back({~w, a inside {8'h20, 8'h24, 8'h28, 8'h2c}, v});
        @(posedge clk);
        #1;
        cfg_sel = 1'b1;
        cfg_wr = w;
        cfg_addr = a;
        cfg_be = 4'hf;
        cfg_wdata = d;
        txn_i.valid = 1'b0;
    endtask

    task automatic dq(input logic io, input logic [31:0] a);
        rq.push_back(dec(io, a));
        @(posedge clk);
        #1;
        cfg_sel = 1'b0;
        txn_i = '{valid: 1'b1, is_io: io, addr: a};
    endtask

    task automatic idle();
        @(posedge clk);
        #1;
        cfg_sel = 1'b0;
        txn_i.valid = 1'b0;
    endtask

    // strap is caught after release, so the mode shadow follows it
    task automatic rst(input logic strap);
        idle();
        rst_n = 1'b0;
        host.io32_strap = strap;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        {m0t, m1b, m1t, iol, ioh, md32} = {96'h0, 32'h0, strap};
        repeat (2) @(posedge clk);
    endtask

    task automatic sweep();
        foreach (sw[i]) dq(sw[i][32], sw[i][31:0]);
        idle();
    endtask

    // scoreboard: oldest note against each answer
    always @(posedge clk) begin
        #2;
        if (cfg_ack === 1'b1) begin
            ce = (cq.size() > 0) ? cq.pop_front() : '1;
            check("cfg_claim", 64'(cfg_claim), 64'(ce[32]));
            if (ce[33]) check("cfg_rdata", 64'(cfg_rdata), 64'(ce[31:0]));
        end
        if (result.valid === 1'b1) begin
            check("result", 64'(result), (rq.size() > 0) ? 64'(rq.pop_front()) : '1);
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        rst(1'b0);
        foreach (offs[i]) cfg(1'b0, offs[i], 32'h0);
        foreach (offs[i]) cfg(1'b1, offs[i], xs());
        foreach (offs[i]) cfg(1'b0, offs[i], 32'h0);
        host.mem_window0_bottom = 32'h1000_0000;
        host.io_window0_top = 32'h0001_10ff;
        cfg(1'b1, 8'h20, 32'h1000_0abc);
        cfg(1'b1, 8'h24, 32'h2000_0000);
        cfg(1'b1, 8'h28, 32'h2000_3000);
        cfg(1'b1, 8'h2c, 32'hffff_1000);
        idle();
        for (int k = 0; k < 16; k++) begin
            host.pci_command = {14'h0, k[1:0]};
            host.bridge_control = {7'h0, k[2], 8'h00};
            host.legacy_16bit_card = k[3];
            sweep();
        end
        // back to a cardbus card, else every later decode is blocked anyway
        host.legacy_16bit_card = 1'b0;
        for (int k = 0; k < 20; k++) dq(seed[0], xs());
        cfg(1'b1, 8'h28, 32'h1fff_f000);
        idle();
        host.pci_command = 16'h0003;
        sweep();
        cfg(1'b1, 8'h28, 32'h2000_0fff);
        sweep();
        rst(1'b1);
        cfg(1'b0, 8'h2c, 32'h0);
        cfg(1'b1, 8'h2c, 32'h0002_1003);
        cfg(1'b0, 8'h2c, 32'h0);
        idle();
        host.io_window0_top = 32'h0002_10ff;
        host.pci_command = 16'h0001;
        dq(1'b1, 32'h0002_1000);
        dq(1'b1, 32'h0000_1000);
        idle();
        for (int k = 0; k < 20 && (cq.size() + rq.size()) > 0; k++) @(posedge clk);
        if (cq.size() + rq.size() > 0) mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
